// ==== common/frm_pkg.sv ====
// Shared constants and types for the fault reaction and configuration load block.
// Assumes a 32-bit AHB-Lite register port and a single 50 MHz clock.
package frm_pkg;

  // Register byte addresses on the bus.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_LATCH = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_TAG = 8'h0C;
  localparam logic [7:0] ADDR_FCLR = 8'h10;
  localparam logic [7:0] ADDR_LCLR = 8'h14;
  localparam logic [7:0] ADDR_NVM = 8'h18;
  localparam logic [7:0] ADDR_STATE = 8'h1C;

  // Decoded register indices.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_LATCH = 4'h1;
  localparam logic [3:0] REG_CFG = 4'h2;
  localparam logic [3:0] REG_TAG = 4'h3;
  localparam logic [3:0] REG_FCLR = 4'h4;
  localparam logic [3:0] REG_LCLR = 4'h5;
  localparam logic [3:0] REG_NVM = 4'h6;
  localparam logic [3:0] REG_STATE = 4'h7;
  localparam logic [3:0] REG_NONE = 4'hF;

  // Status flag positions.
  localparam int ST_OCP = 0;
  localparam int ST_LR = 3;
  localparam int ST_WD_DRV = 4;
  localparam int ST_WD_BUCK = 5;
  localparam int ST_WD_CP = 6;
  localparam int ST_WD_OTH = 7;
  localparam int ST_OTS = 8;
  localparam int ST_OTW = 9;
  localparam int ST_NVM = 10;
  localparam int ST_W = 11;

  // Latch positions.
  localparam int LT_OCP_HIZ = 0;
  localparam int LT_OCP_BRK = 3;
  localparam int LT_LR = 4;
  localparam int LT_WD_BRK = 5;
  localparam int LT_OTS = 6;
  localparam int LT_NVM = 7;
  localparam int LT_W = 8;

  // Configuration word fields.
  localparam int CF_OCP_LATCH = 0;
  localparam int CF_OCP_BRK = 3;
  localparam int CF_WD_BRK = 4;
  localparam int CF_PAT = 5;
  localparam logic [15:0] CFG_MASK = 16'h00FF;

  // Priority codes, smaller wins.
  localparam logic [3:0] PRIO_OTS = 4'h3;
  localparam logic [3:0] PRIO_OCP = 4'h4;
  localparam logic [3:0] PRIO_LR = 4'h5;
  localparam logic [3:0] PRIO_WD = 4'h6;
  localparam logic [3:0] PRIO_NVM = 4'h7;
  localparam logic [3:0] PRIO_OTW = 4'h8;
  localparam logic [3:0] PRIO_NONE = 4'hF;

  // Factory content of the one-time store; values are arbitrary.
  localparam logic [15:0] NVM_CFG_RST = 16'h0000;
  localparam logic [15:0] NVM_TAG_RST = 16'h0000;
  localparam int NVM_WORDS = 2;

  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [2:0] PAT_RST = 3'h0;

  typedef enum logic [1:0] {
    FS_LOAD = 2'b00,
    FS_STANDBY = 2'b01,
    FS_ACTIVE = 2'b11,
    FS_STOP = 2'b10
  } frm_state_e;

endpackage

// ==== core/frm_nvm.sv ====
// One-time-programmable configuration store with indexed read port.
// Assumes nvm_init_n is pulsed once at simulated manufacture only; it is not the power-on reset.
`timescale 1ns/100ps
module frm_nvm
  import frm_pkg::*;
(
  input wire logic clk,
  input wire logic nvm_init_n,
  input wire logic rd_idx,
  output logic [15:0] rd_data,
  input wire logic prog_req,
  input wire logic [15:0] prog_cfg,
  input wire logic [15:0] prog_tag,
  output logic used,
  output logic rejected
);

  typedef struct packed {
    logic [NVM_WORDS-1:0][15:0] mem;
    logic used;
    logic rejected;
  } frm_nvm_s;

  frm_nvm_s s_r;
  frm_nvm_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rejected = 1'b0;
    if (prog_req) begin
      if (s_r.used) begin
        s_nxt.rejected = 1'b1;
      end else begin
        s_nxt.mem[0] = prog_cfg;
        s_nxt.mem[1] = prog_tag;
        s_nxt.used = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nvm_init_n) begin
      s_r.mem[0] <= NVM_CFG_RST;
      s_r.mem[1] <= NVM_TAG_RST;
      s_r.used <= 1'b0;
      s_r.rejected <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.mem[rd_idx];
  assign used = s_r.used;
  assign rejected = s_r.rejected;

endmodule

// ==== core/frm_core.sv ====
// Fault reaction manager with start-up mirroring of the one-time configuration store.
// Assumes an AHB-Lite master with this block as the only slave and synchronous fault inputs.
// How it works
// - Smallest priority code with a requested reaction chooses it.
// - Latched phase overcurrent forces gates high-impedance.
// - Overcurrent brake enable brakes and latches fault.
// - Locked rotor latches, reports, stops until toggle.
// - Enable watchdog overflow tri-states and reports.
// - Buck watchdog overflow gets no reaction.
// - Charge pump watchdog reports, blocks start-up.
// - Other watchdogs brake and latch when enabled.
// - Overtemperature shutdown latches, reports, tri-states.
// - Overtemperature warning only sets a status flag.
// - Store fault latches, reports, tri-states always.
// - Working configuration is volatile, lost on reset.
// - Start-up copies stored defaults into working configuration.
// - Store accepts one programming, rejects later ones.
// - Software may rewrite working configuration anytime.
// - Readable user tag stored with configuration.
// - Plain faults and latches cleared separately.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module frm_core
  import frm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nvm_init_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic driver_enable_pin,
  input wire logic [2:0] ocp_event,
  input wire logic locked_rotor_ovf,
  input wire logic wd_drv_ovf,
  input wire logic wd_buck_ovf,
  input wire logic wd_cp_ovf,
  input wire logic wd_other_ovf,
  input wire logic overtemp_shutdown,
  input wire logic overtemp_warning,
  input wire logic nvm_read_fault,
  output logic gate_hiz,
  output logic brake_active,
  output logic [2:0] brake_pattern,
  output logic fault_out_n
);

  typedef struct packed {
    frm_state_e fsm;
    logic ld_idx;
    logic [15:0] cfg;
    logic [15:0] tag;
    logic [ST_W-1:0] st;
    logic [LT_W-1:0] lat;
    logic cp_block;
    logic prog_req;
    logic prog_err;
    logic gate_hiz;
    logic brake;
    logic [2:0] pat;
    logic fault_n;
    logic [3:0] prio;
    logic ap_wr;
    logic ap_rd;
    logic [3:0] ap_reg;
    logic rd_wait;
    logic hready;
    logic [31:0] hrdata;
  } frm_core_s;

  frm_core_s s_r;
  frm_core_s s_nxt;

  logic [15:0] nvm_rd_data;
  logic nvm_used;
  logic nvm_rejected;

  frm_nvm u_nvm (
    .clk(clk),
    .nvm_init_n(nvm_init_n),
    .rd_idx(s_r.ld_idx),
    .rd_data(nvm_rd_data),
    .prog_req(s_r.prog_req),
    .prog_cfg(s_r.cfg),
    .prog_tag(s_r.tag),
    .used(nvm_used),
    .rejected(nvm_rejected)
  );

  // Byte address to register index; anything else is unmapped.
  function automatic logic [3:0] reg_decode(input logic [31:0] a);
    logic [3:0] r;
    r = REG_NONE;
    if (a[31:8] == 24'h00_0000) begin
      unique case (a[7:0])
        ADDR_STATUS: r = REG_STATUS;
        ADDR_LATCH: r = REG_LATCH;
        ADDR_CFG: r = REG_CFG;
        ADDR_TAG: r = REG_TAG;
        ADDR_FCLR: r = REG_FCLR;
        ADDR_LCLR: r = REG_LCLR;
        ADDR_NVM: r = REG_NVM;
        ADDR_STATE: r = REG_STATE;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Smallest priority code with a request, or PRIO_NONE.
  function automatic logic [3:0] top_prio(input logic [8:0] req);
    logic [3:0] p;
    p = PRIO_NONE;
    for (int i = 8; i >= 0; i--) begin
      if (req[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  logic active;
  logic [ST_W-1:0] ev;
  logic [LT_W-1:0] lat_set;
  logic [8:0] pend;
  logic [8:0] hiz_req;
  logic [8:0] brk_req;
  logic [3:0] act_prio;
  logic report;
  logic hiz_latched;
  logic [3:0] wr_reg;
  logic [3:0] ad_reg;
  logic ad_valid;

  always_comb begin
    active = (s_r.fsm == FS_ACTIVE);
    ev = '0;
    ev[ST_OCP +: 3] = ocp_event & {3{active}};
    ev[ST_LR] = locked_rotor_ovf & active;
    ev[ST_WD_DRV] = wd_drv_ovf & active;
    ev[ST_WD_BUCK] = wd_buck_ovf;
    ev[ST_WD_CP] = wd_cp_ovf & (s_r.fsm == FS_STANDBY);
    ev[ST_WD_OTH] = wd_other_ovf & active;
    ev[ST_OTS] = overtemp_shutdown & active;
    ev[ST_OTW] = overtemp_warning & active;
    ev[ST_NVM] = nvm_read_fault | s_r.prog_err;

    lat_set = '0;
    lat_set[LT_OCP_HIZ +: 3] = ev[ST_OCP +: 3] & s_r.cfg[CF_OCP_LATCH +: 3];
    lat_set[LT_OCP_BRK] = (|ev[ST_OCP +: 3]) & s_r.cfg[CF_OCP_BRK];
    lat_set[LT_LR] = ev[ST_LR];
    lat_set[LT_WD_BRK] = ev[ST_WD_OTH] & s_r.cfg[CF_WD_BRK];
    lat_set[LT_OTS] = ev[ST_OTS];
    lat_set[LT_NVM] = ev[ST_NVM];

    // Pending work and requested reaction per priority code.
    pend = '0;
    hiz_req = '0;
    brk_req = '0;
    pend[PRIO_OTS] = s_r.lat[LT_OTS];
    pend[PRIO_OCP] = (|s_r.st[ST_OCP +: 3]) | (|s_r.lat[LT_OCP_HIZ +: 4]);
    pend[PRIO_LR] = s_r.lat[LT_LR];
    pend[PRIO_WD] = s_r.st[ST_WD_DRV] | s_r.st[ST_WD_CP] | s_r.st[ST_WD_OTH]
                    | s_r.lat[LT_WD_BRK];
    pend[PRIO_NVM] = s_r.lat[LT_NVM];
    pend[PRIO_OTW] = s_r.st[ST_OTW];
    hiz_req[PRIO_OTS] = s_r.lat[LT_OTS];
    hiz_req[PRIO_OCP] = |s_r.lat[LT_OCP_HIZ +: 3];
    brk_req[PRIO_OCP] = s_r.lat[LT_OCP_BRK];
    hiz_req[PRIO_LR] = s_r.lat[LT_LR];
    hiz_req[PRIO_WD] = s_r.st[ST_WD_DRV];
    brk_req[PRIO_WD] = s_r.lat[LT_WD_BRK];
    hiz_req[PRIO_NVM] = s_r.lat[LT_NVM];
    act_prio = top_prio(hiz_req | brk_req);

    report = (|s_r.st[ST_OCP +: 3]) | s_r.st[ST_WD_DRV] | s_r.st[ST_WD_CP]
             | (|s_r.lat);
    hiz_latched = (|s_r.lat[LT_OCP_HIZ +: 3]) | s_r.lat[LT_LR] | s_r.lat[LT_OTS]
                  | s_r.lat[LT_NVM] | s_r.st[ST_WD_DRV];

    ad_valid = hsel & hready & htrans[1];
    ad_reg = reg_decode(haddr);
    wr_reg = s_r.ap_wr ? s_r.ap_reg : REG_NONE;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.prog_req = 1'b0;
    s_nxt.prog_err = 1'b0;
    s_nxt.st = s_r.st | ev;
    s_nxt.lat = s_r.lat | lat_set;

    if (wr_reg == REG_FCLR && hwdata[0]) begin
      s_nxt.st = ev;
      s_nxt.cp_block = 1'b0;
    end
    if (wr_reg == REG_LCLR && hwdata[0]) begin
      s_nxt.lat = (s_r.lat & (LT_W'(1) << LT_LR)) | lat_set;
    end
    if (wr_reg == REG_CFG) begin
      s_nxt.cfg = hwdata[15:0] & CFG_MASK;
    end
    if (wr_reg == REG_TAG) begin
      s_nxt.tag = hwdata[15:0];
    end
    if (wr_reg == REG_NVM && hwdata[0]) begin
      s_nxt.prog_req = 1'b1;
    end
    if (nvm_rejected) begin
      s_nxt.prog_err = 1'b0;
    end

    unique case (s_r.fsm)
      FS_LOAD: begin
        if (!s_r.ld_idx) begin
          s_nxt.cfg = nvm_rd_data & CFG_MASK;
          s_nxt.ld_idx = 1'b1;
        end else begin
          s_nxt.tag = nvm_rd_data;
          s_nxt.ld_idx = 1'b0;
          s_nxt.fsm = FS_STANDBY;
        end
      end
      FS_STANDBY: begin
        if (ev[ST_WD_CP]) begin
          s_nxt.cp_block = 1'b1;
        end
        if (driver_enable_pin && !s_r.cp_block && !ev[ST_WD_CP] && !hiz_latched) begin
          s_nxt.fsm = FS_ACTIVE;
        end
      end
      FS_ACTIVE: begin
        if (!driver_enable_pin) begin
          s_nxt.fsm = FS_STANDBY;
        end else if (hiz_latched) begin
          s_nxt.fsm = FS_STOP;
        end
      end
      FS_STOP: begin
        if (!driver_enable_pin) begin
          s_nxt.fsm = FS_STANDBY;
        end
      end
    endcase

    if (!driver_enable_pin) begin
      s_nxt.lat[LT_LR] = lat_set[LT_LR];
    end

    // Outputs follow the winning reaction; the gates stay off outside the active state.
    s_nxt.prio = top_prio(pend);
    s_nxt.brake = active && act_prio != PRIO_NONE && !hiz_req[act_prio];
    s_nxt.gate_hiz = !active || (act_prio != PRIO_NONE && hiz_req[act_prio]);
    s_nxt.pat = s_r.cfg[CF_PAT +: 3];
    s_nxt.fault_n = !report;

    // Reads take one wait state so that a write just before is already visible.
    s_nxt.ap_wr = 1'b0;
    s_nxt.ap_rd = 1'b0;
    s_nxt.hready = 1'b1;
    if (s_r.rd_wait) begin
      s_nxt.rd_wait = 1'b0;
      s_nxt.hrdata = RDATA_RST;
      unique case (s_r.ap_reg)
        REG_STATUS: s_nxt.hrdata[ST_W-1:0] = s_r.st;
        REG_LATCH: s_nxt.hrdata[LT_W-1:0] = s_r.lat;
        REG_CFG: s_nxt.hrdata[15:0] = s_r.cfg;
        REG_TAG: s_nxt.hrdata[15:0] = s_r.tag;
        REG_NVM: s_nxt.hrdata[1:0] = {s_r.lat[LT_NVM], nvm_used};
        REG_STATE: s_nxt.hrdata[9:0] = {s_r.cp_block, s_r.fault_n, s_r.prio, s_r.fsm,
                                        s_r.brake, s_r.gate_hiz};
        default: s_nxt.hrdata = RDATA_RST;
      endcase
    end else if (ad_valid) begin
      s_nxt.ap_reg = ad_reg;
      if (hwrite) begin
        s_nxt.ap_wr = 1'b1;
      end else begin
        s_nxt.ap_rd = 1'b1;
        s_nxt.rd_wait = 1'b1;
        s_nxt.hready = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.fsm <= FS_LOAD;
      s_r.ld_idx <= 1'b0;
      s_r.cfg <= '0;
      s_r.tag <= '0;
      s_r.st <= '0;
      s_r.lat <= '0;
      s_r.cp_block <= 1'b0;
      s_r.prog_req <= 1'b0;
      s_r.prog_err <= 1'b0;
      s_r.gate_hiz <= 1'b1;
      s_r.brake <= 1'b0;
      s_r.pat <= PAT_RST;
      s_r.fault_n <= 1'b1;
      s_r.prio <= PRIO_NONE;
      s_r.ap_wr <= 1'b0;
      s_r.ap_rd <= 1'b0;
      s_r.ap_reg <= REG_NONE;
      s_r.rd_wait <= 1'b0;
      s_r.hready <= 1'b1;
      s_r.hrdata <= RDATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hready;
  assign hrdata = s_r.hrdata;
  assign hresp = 1'b0;
  assign gate_hiz = s_r.gate_hiz;
  assign brake_active = s_r.brake;
  assign brake_pattern = s_r.pat;
  assign fault_out_n = s_r.fault_n;

endmodule

// ==== testbench/frm_core_assertions.sv ====
// Port-level checks for frm_core, bound into every instance.
// Assumes fault inputs are synchronous to clk and rst_n is active low.
`timescale 1ns/100ps
module frm_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic driver_enable_pin,
  input wire logic [2:0] ocp_event,
  input wire logic locked_rotor_ovf,
  input wire logic wd_drv_ovf,
  input wire logic wd_buck_ovf,
  input wire logic wd_cp_ovf,
  input wire logic wd_other_ovf,
  input wire logic overtemp_shutdown,
  input wire logic overtemp_warning,
  input wire logic nvm_read_fault,
  input wire logic gate_hiz,
  input wire logic brake_active,
  input wire logic fault_out_n
);
  logic quiet;
  // Buck and warning inputs are left out, since neither may pull the fault pin.
  assign quiet = ~|{ocp_event, locked_rotor_ovf, wd_drv_ovf, wd_cp_ovf, wd_other_ovf,
    overtemp_shutdown, nvm_read_fault};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_hiz_rep;
    gate_hiz && !fault_out_n;
  endsequence
  sequence s_hiz_only;
    gate_hiz && !brake_active;
  endsequence
  // A low gate_hiz shows the driver was running when the fault came.
  sequence s_lr_hit;
    locked_rotor_ovf && !gate_hiz;
  endsequence
  sequence s_ots_wd;
    overtemp_shutdown && wd_other_ovf && !gate_hiz;
  endsequence
  sequence s_soft;
    quiet && (wd_buck_ovf || overtemp_warning) && fault_out_n;
  endsequence
  sequence s_rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  a_ots_react: assert property (overtemp_shutdown && !gate_hiz |-> ##[1:2] s_hiz_rep)
    else $error("shutdown not reacted");
  a_lr_react: assert property (s_lr_hit |-> ##[1:2] s_hiz_rep)
    else $error("locked rotor not reacted");
  a_lr_hold: assert property (s_lr_hit ##1 driver_enable_pin [*8] |-> gate_hiz)
    else $error("locked rotor released early");
  a_wdd_react: assert property (wd_drv_ovf && !gate_hiz |-> ##[1:2] s_hiz_rep)
    else $error("enable watchdog not reacted");
  a_store_react: assert property (nvm_read_fault |-> ##[1:2] s_hiz_rep)
    else $error("store fault not reacted");
  a_prio_wins: assert property (s_ots_wd |-> ##[1:2] s_hiz_only)
    else $error("lower priority reaction won");
  a_en_low: assert property (!driver_enable_pin [*2] |=> s_hiz_only)
    else $error("driver not stopped by enable low");
  a_soft_quiet: assert property (quiet ##1 s_soft |=> fault_out_n)
    else $error("fault pin driven by silent fault");
  a_rd_wait: assert property (s_rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_wr_zero: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
endmodule

bind frm_core frm_chk frm_chk_i (.clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .driver_enable_pin, .ocp_event, .locked_rotor_ovf, .wd_drv_ovf, .wd_buck_ovf, .wd_cp_ovf,
  .wd_other_ovf, .overtemp_shutdown, .overtemp_warning, .nvm_read_fault, .gate_hiz,
  .brake_active, .fault_out_n);

// ==== testbench/frm_mcu.sv ====
// Bus master model standing in for the controlling microcontroller.
// Assumes it is the only master and the slave's hreadyout comes back as hready.
`timescale 1ns/100ps
module frm_mcu (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    // Stale write data is inverted so no slave can lean on it.
    hwdata <= ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr_rb(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for frm_core: configuration store, reloads and fault reactions.
// Assumes frm_mcu drives the bus and frm_chk is bound onto the core.
`timescale 1ns/100ps
module tb
  import frm_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_n, nvm_init_n, driver_enable_pin, hsel, hwrite, hreadyout, hresp;
  logic gate_hiz, brake_active, fault_out_n;
  logic [1:0] htrans;
  logic [2:0] hsize, brake_pattern;
  logic [10:0] flt;
  logic [31:0] haddr, hwdata, hrdata, q;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  frm_core frm_core_i (.clk, .rst_n, .nvm_init_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .driver_enable_pin,
    .ocp_event(flt[2:0]), .locked_rotor_ovf(flt[ST_LR]), .wd_drv_ovf(flt[ST_WD_DRV]),
    .wd_buck_ovf(flt[ST_WD_BUCK]), .wd_cp_ovf(flt[ST_WD_CP]), .wd_other_ovf(flt[ST_WD_OTH]),
    .overtemp_shutdown(flt[ST_OTS]), .overtemp_warning(flt[ST_OTW]),
    .nvm_read_fault(flt[ST_NVM]), .gate_hiz, .brake_active, .brake_pattern, .fault_out_n);
  frm_mcu frm_mcu_i (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    frm_mcu_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    frm_mcu_i.xfer(1'b1, a, d, q);
  endtask
  // The store keeps its content unless init is asked for, like a real power cycle.
  task automatic do_reset(input logic init);
    @(posedge clk);
    rst_n <= 1'b0;
    nvm_init_n <= ~init;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    nvm_init_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Clears everything, loads cfg, pulses the faults in m and checks the reaction.
  task automatic fault_case(input logic [10:0] m, input logic [7:0] cfg, input logic act,
      input logic [2:0] exp);
    driver_enable_pin <= 1'b0;
    wr(ADDR_FCLR, 32'h1);
    wr(ADDR_LCLR, 32'h1);
    wr(ADDR_CFG, {24'h0, cfg});
    driver_enable_pin <= act;
    repeat (4) @(posedge clk);
    chk(fault_out_n, 1'b1);
    flt <= m;
    @(posedge clk);
    flt <= '0;
    repeat (3) @(posedge clk);
    chk({gate_hiz, brake_active, fault_out_n}, exp);
    rd(ADDR_STATUS);
    chk(q[10:0] & m, m);
  endtask

  task automatic t_cfg_store;
    rd(ADDR_CFG);
    chk(q, {16'h0, NVM_CFG_RST});
    rd(ADDR_TAG);
    chk(q, {16'h0, NVM_TAG_RST});
    rd(8'h40);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    frm_mcu_i.wr_rb(ADDR_CFG, 32'hA5, q);
    chk(q, 32'hA5);
    frm_mcu_i.wr_rb(ADDR_TAG, 32'h1234, q);
    chk(q, 32'h1234);
    wr(ADDR_NVM, 32'h1);
    rd(ADDR_NVM);
    chk(q[0], 1'b1);
    wr(ADDR_CFG, 32'h3C);
    wr(ADDR_NVM, 32'h1);
    do_reset(1'b0);
    rd(ADDR_CFG);
    chk(q, 32'hA5);
    rd(ADDR_TAG);
    chk(q, 32'h1234);
  endtask
  task automatic t_overcurrent;
    fault_case(11'h002, 8'h02, 1'b1, 3'b100);
    fault_case(11'h004, 8'h00, 1'b1, 3'b000);
    fault_case(11'h001, 8'hA8, 1'b1, 3'b010);
    chk(brake_pattern, 3'b101);
    rd(ADDR_LATCH);
    chk(q[LT_OCP_BRK], 1'b1);
  endtask
  task automatic t_watchdog;
    fault_case(11'h010, 8'h00, 1'b1, 3'b100);
    fault_case(11'h020, 8'h00, 1'b1, 3'b001);
    fault_case(11'h040, 8'h00, 1'b0, 3'b100);
    driver_enable_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk(gate_hiz, 1'b1);
    fault_case(11'h080, 8'h50, 1'b1, 3'b010);
    chk(brake_pattern, 3'b010);
    rd(ADDR_LATCH);
    chk(q[LT_WD_BRK], 1'b1);
  endtask
  task automatic t_locked_rotor;
    fault_case(11'h008, 8'h00, 1'b1, 3'b100);
    wr(ADDR_LCLR, 32'h1);
    wr(ADDR_FCLR, 32'h1);
    repeat (4) @(posedge clk);
    chk({gate_hiz, fault_out_n}, 2'b10);
  endtask
  task automatic t_temperature;
    fault_case(11'h100, 8'h00, 1'b1, 3'b100);
    wr(ADDR_FCLR, 32'h1);
    chk(fault_out_n, 1'b0);
    wr(ADDR_LCLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(fault_out_n, 1'b1);
    fault_case(11'h200, 8'h00, 1'b1, 3'b001);
  endtask
  task automatic t_store_fault;
    fault_case(11'h400, 8'h00, 1'b0, 3'b100);
    fault_case(11'h400, 8'h00, 1'b1, 3'b100);
  endtask
  task automatic t_priority;
    fault_case(11'h180, 8'hB0, 1'b1, 3'b100);
    rd(ADDR_STATE);
    chk(q[7:4], PRIO_OTS);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    nvm_init_n = 1'b0;
    driver_enable_pin = 1'b0;
    flt = '0;
    do_reset(1'b1);
    t_cfg_store();
    t_overcurrent();
    t_watchdog();
    t_locked_rotor();
    t_temperature();
    t_store_fault();
    t_priority();
    report_and_stop();
  end
endmodule
